// >>> design/dcibs_pkg.sv
// dcibs_pkg: constants, register map and types of the dc injection brake sequencer
// assumes: 250 MHz mclk_in, plain register port with one-cycle read latency
package dcibs_pkg;
	// ------------------------------------------------------------
	// clock and time bases
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned DIV_HZ = 250_000_000;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] REG_ENABLE_OFS = 4'h0;
	localparam logic [3:0] REG_START_FREQ_OFS = 4'h1;
	localparam logic [3:0] REG_WAIT_OFS = 4'h2;
	localparam logic [3:0] REG_STOP_FORCE_OFS = 4'h3;
	localparam logic [3:0] REG_STOP_DUR_OFS = 4'h4;
	localparam logic [3:0] REG_DETECT_OFS = 4'h5;
	localparam logic [3:0] REG_START_FORCE_OFS = 4'h6;
	localparam logic [3:0] REG_START_DUR_OFS = 4'h7;
	localparam logic [3:0] REG_CARRIER_OFS = 4'h8;
	localparam logic [3:0] REG_CONFIG_OFS = 4'h9;
	localparam logic [3:0] REG_STATUS_OFS = 4'hA;

	// ------------------------------------------------------------
	// field codes, limits and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] ENABLE_OFF = 2'h0;
	localparam logic [1:0] ENABLE_ON = 2'h1;
	localparam logic [1:0] ENABLE_SET_FREQ_ONLY = 2'h2;
	localparam logic [0:0] DETECT_EDGE = 1'h0;
	localparam logic [0:0] DETECT_LEVEL = 1'h1;
	localparam logic [4:0] EXT_REQUEST_FUNC = 5'h07;
	localparam logic [15:0] START_FREQ_MAX = 16'h1770;
	localparam logic [15:0] WAIT_MAX = 16'h0032;
	localparam logic [15:0] FORCE_MAX = 16'h0050;
	localparam logic [15:0] DUR_MAX = 16'h0258;
	localparam logic [15:0] CARRIER_MIN = 16'h0005;
	localparam logic [15:0] CARRIER_MAX = 16'h0096;
	localparam logic [1:0] RST_ENABLE = ENABLE_OFF;
	localparam logic [15:0] RST_START_FREQ = 16'h0032;
	localparam logic [15:0] RST_WAIT = 16'h0000;
	localparam logic [15:0] RST_FORCE = 16'h0000;
	localparam logic [15:0] RST_DUR = 16'h0000;
	localparam logic [0:0] RST_DETECT = DETECT_LEVEL;
	localparam logic [15:0] RST_CARRIER = 16'h001E;
	localparam logic [15:0] RST_CONFIG = 16'h0003;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DCIBS_IDLE,
		DCIBS_RUN,
		DCIBS_WAIT,
		DCIBS_BRAKE_STOP,
		DCIBS_BRAKE_START,
		DCIBS_STOPPED
	} dcibs_state_type;

	function automatic logic [15:0] dcibs_clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction : dcibs_clamp
endpackage : dcibs_pkg

// >>> design/dcibs_sync.sv
// dcibs_sync: three-flop input synchroniser with agreement filter
// assumes: asynchronous pin input, synchronous active-high reset
`timescale 1ns/1ps
module dcibs_sync
	import dcibs_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// pin and filtered level
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg;
	logic lvl_next, rise_next;

	always_comb
	begin
		lvl_next = lvl_reg;
		if (s2_reg == s3_reg)
			lvl_next = s3_reg;
		rise_next = lvl_next & ~lvl_reg;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
			rise_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			rise_reg <= rise_next;
		end
	end

	assign level_out = lvl_reg;
	assign rise_out = rise_reg;
endmodule : dcibs_sync

// >>> design/dcibs_carrier.sv
// dcibs_carrier: braking carrier pwm with force derated by carrier setting
// assumes: carrier in 0.1 kHz units, force in percent
`timescale 1ns/1ps
module dcibs_carrier
	import dcibs_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// settings
	input wire logic enable_in,
	input wire logic [15:0] carrier_in,
	input wire logic [15:0] force_in,
	// pwm output
	output logic pwm_out,
	output logic [15:0] force_eff_out
);
	logic [31:0] period_reg, period_next, cnt_reg, cnt_next;
	logic [15:0] eff_reg, eff_next, limit;
	logic pwm_reg, pwm_next;
	logic [47:0] on_cycles;

	always_comb
	begin
		// higher carrier leaves less available force [RULE18]
		limit = FORCE_MAX - 16'(carrier_in / 16'h0004);
		eff_next = (force_in > limit) ? limit : force_in;
		period_next = 32'(CLK_HZ / 100) / 32'(dcibs_clamp(carrier_in, CARRIER_MIN,
			CARRIER_MAX));
		cnt_next = (!enable_in || cnt_reg + 32'h1 >= period_reg) ? 32'h0 : cnt_reg + 32'h1;
		on_cycles = 48'(period_reg) * 48'(eff_reg) / 48'h64;
		pwm_next = enable_in && (48'(cnt_reg) < on_cycles);
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			period_reg <= 32'h0;
			cnt_reg <= 32'h0;
			eff_reg <= 16'h0;
			pwm_reg <= 1'b0;
		end
		else
		begin
			period_reg <= period_next;
			cnt_reg <= cnt_next;
			eff_reg <= eff_next;
			pwm_reg <= pwm_next;
		end
	end

	assign pwm_out = pwm_reg;
	assign force_eff_out = eff_reg;
endmodule : dcibs_carrier

// >>> design/dcibs_top.sv
// dcibs_top: dc injection brake sequencer with register port
// assumes: frequency in 0.01 Hz, times in 0.1 s, one 250 MHz clock
// Behaviour
// RULE1: brake decelerating below programmed start frequency
// RULE2: coast output off for wait time first
// RULE3: wait time also follows external request
// RULE4: separate stop force, zero to eighty
// RULE5: stop braking lasts programmed stop duration
// RULE6: run command brakes first, own force/duration
// RULE7: stop only, start only, or both
// RULE8: enable field: off, on, frequency only
// RULE9: enabled means automatic braking, no request
// RULE10: function code 7 overrides enable field
// RULE11: external mode uses forces, ignores durations
// RULE12: detect select: edge or level, default level
// RULE13: level mode brakes while request held
// RULE14: edge while running brakes until stopped
// RULE15: edges ignored in stop state
// RULE16: host avoids edge mode for start braking
// RULE17: braking uses own programmable carrier
// RULE18: higher carrier reduces available braking force
// RULE19: duration end removes output, start accelerates
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module dcibs_top
	import dcibs_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// drive state
	input wire logic run_cmd_in,
	input wire logic decel_in,
	input wire logic motor_stopped_in,
	input wire logic [15:0] out_freq_in,
	input wire logic ext_brake_request_in,
	// output stage
	output logic brake_active_out,
	output logic output_off_out,
	output logic brake_pwm_out,
	output logic [15:0] brake_force_out,
	output logic accel_release_out
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [1:0] en_reg, en_next;
	logic [15:0] sfreq_reg, sfreq_next, wait_reg, wait_next;
	logic [15:0] sforce_reg, sforce_next, sdur_reg, sdur_next;
	logic [15:0] tforce_reg, tforce_next, tdur_reg, tdur_next;
	logic [15:0] car_reg, car_next, cfg_reg, cfg_next;
	logic det_reg, det_next;
	logic [15:0] rdata_reg, rdata_next;
	logic [15:0] status;

	always_comb
	begin
		en_next = en_reg;
		sfreq_next = sfreq_reg;
		wait_next = wait_reg;
		sforce_next = sforce_reg;
		sdur_next = sdur_reg;
		det_next = det_reg;
		tforce_next = tforce_reg;
		tdur_next = tdur_reg;
		car_next = car_reg;
		cfg_next = cfg_reg;
		if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				REG_ENABLE_OFS: en_next = (reg_wdata_in[1:0] == 2'h3) ? en_reg : reg_wdata_in[1:0]; // [RULE8]
				REG_START_FREQ_OFS: sfreq_next = dcibs_clamp(reg_wdata_in, 16'h0, START_FREQ_MAX);
				REG_WAIT_OFS: wait_next = dcibs_clamp(reg_wdata_in, 16'h0, WAIT_MAX);
				REG_STOP_FORCE_OFS: sforce_next = dcibs_clamp(reg_wdata_in, 16'h0, FORCE_MAX);
				REG_STOP_DUR_OFS: sdur_next = dcibs_clamp(reg_wdata_in, 16'h0, DUR_MAX);
				REG_DETECT_OFS: det_next = reg_wdata_in[0]; // [RULE12]
				REG_START_FORCE_OFS: tforce_next = dcibs_clamp(reg_wdata_in, 16'h0, FORCE_MAX);
				REG_START_DUR_OFS: tdur_next = dcibs_clamp(reg_wdata_in, 16'h0, DUR_MAX);
				REG_CARRIER_OFS: car_next = dcibs_clamp(reg_wdata_in, CARRIER_MIN, CARRIER_MAX);
				REG_CONFIG_OFS: cfg_next = reg_wdata_in & 16'h00FF; // [RULE10]
				default: ;
			endcase
		end
		rdata_next = 16'h0;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				REG_ENABLE_OFS: rdata_next = {14'h0, en_reg};
				REG_START_FREQ_OFS: rdata_next = sfreq_reg;
				REG_WAIT_OFS: rdata_next = wait_reg;
				REG_STOP_FORCE_OFS: rdata_next = sforce_reg;
				REG_STOP_DUR_OFS: rdata_next = sdur_reg;
				REG_DETECT_OFS: rdata_next = {15'h0, det_reg};
				REG_START_FORCE_OFS: rdata_next = tforce_reg;
				REG_START_DUR_OFS: rdata_next = tdur_reg;
				REG_CARRIER_OFS: rdata_next = car_reg;
				REG_CONFIG_OFS: rdata_next = cfg_reg;
				REG_STATUS_OFS: rdata_next = status;
				default: rdata_next = 16'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			en_reg <= RST_ENABLE;
			sfreq_reg <= RST_START_FREQ;
			wait_reg <= RST_WAIT;
			sforce_reg <= RST_FORCE;
			sdur_reg <= RST_DUR;
			det_reg <= RST_DETECT;
			tforce_reg <= RST_FORCE;
			tdur_reg <= RST_DUR;
			car_reg <= RST_CARRIER;
			cfg_reg <= RST_CONFIG;
			rdata_reg <= 16'h0;
		end
		else
		begin
			en_reg <= en_next;
			sfreq_reg <= sfreq_next;
			wait_reg <= wait_next;
			sforce_reg <= sforce_next;
			sdur_reg <= sdur_next;
			det_reg <= det_next;
			tforce_reg <= tforce_next;
			tdur_reg <= tdur_next;
			car_reg <= car_next;
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// request input and tick divider
	// ------------------------------------------------------------
	logic req_lvl, req_rise;
	logic [31:0] div_reg, div_next;
	logic tick;

	dcibs_sync u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.pin_in(ext_brake_request_in),
		.level_out(req_lvl),
		.rise_out(req_rise)
	);

	always_comb
	begin
		tick = (div_reg == 32'(TICK_LEN - 1));
		div_next = tick ? 32'h0 : div_reg + 32'h1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			div_reg <= 32'h0;
		else
			div_reg <= div_next;
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// cfg[0] stop braking, cfg[1] start braking, cfg[2] external input assigned
	// cfg[7:3] input function code
	logic ext_mode, stop_en, start_en, freq_hit, ext_trig;
	dcibs_state_type st_reg, st_next;
	logic [15:0] tmr_reg, tmr_next;
	logic xb_reg, xb_next, rel_reg, rel_next, run_q_reg;
	logic braking;
	logic [15:0] force_sel;

	always_comb
	begin
		ext_mode = cfg_reg[2] && (cfg_reg[7:3] == EXT_REQUEST_FUNC); // [RULE10]
		stop_en = cfg_reg[0] && (en_reg == ENABLE_ON); // [RULE7] [RULE9]
		start_en = cfg_reg[1] && (en_reg == ENABLE_ON); // [RULE7] [RULE9]
		freq_hit = decel_in && (out_freq_in < sfreq_reg); // [RULE1]
		// edges count only while running [RULE14] [RULE15]
		ext_trig = (det_reg == DETECT_LEVEL) ? req_lvl : (req_rise && run_cmd_in);
		st_next = st_reg;
		tmr_next = (tick && tmr_reg != 16'h0) ? tmr_reg - 16'h1 : tmr_reg;
		xb_next = xb_reg;
		rel_next = 1'b0;
		unique case (st_reg)
			DCIBS_IDLE:
			begin
				if (ext_mode && ext_trig)
				begin
					st_next = DCIBS_WAIT; // [RULE3]
					tmr_next = wait_reg;
					xb_next = 1'b1;
				end
				else if (!ext_mode && run_cmd_in && !run_q_reg && start_en)
				begin
					st_next = DCIBS_BRAKE_START; // [RULE6]
					tmr_next = tdur_reg;
				end
				else if (run_cmd_in)
					st_next = DCIBS_RUN;
			end
			DCIBS_RUN:
			begin
				if (ext_mode && ext_trig)
				begin
					st_next = DCIBS_WAIT; // [RULE3]
					tmr_next = wait_reg;
					xb_next = 1'b1;
				end
				else if (!ext_mode && freq_hit && (stop_en || en_reg == ENABLE_SET_FREQ_ONLY))
				begin
					st_next = DCIBS_WAIT; // [RULE2]
					tmr_next = wait_reg;
					xb_next = 1'b0;
				end
				else if (!run_cmd_in && motor_stopped_in)
					st_next = DCIBS_IDLE;
			end
			DCIBS_WAIT:
			begin
				if (xb_reg && det_reg == DETECT_LEVEL && !req_lvl)
					st_next = run_cmd_in ? DCIBS_RUN : DCIBS_IDLE;
				else if (tmr_reg == 16'h0)
				begin
					st_next = DCIBS_BRAKE_STOP;
					tmr_next = sdur_reg; // [RULE5]
				end
			end
			DCIBS_BRAKE_STOP:
			begin
				if (xb_reg)
				begin
					// external: durations ignored [RULE11] [RULE13] [RULE14]
					if ((det_reg == DETECT_LEVEL) ? !req_lvl : motor_stopped_in)
						st_next = run_cmd_in ? DCIBS_RUN : DCIBS_IDLE;
				end
				else if (tmr_reg == 16'h0)
					st_next = DCIBS_STOPPED; // [RULE19]
			end
			DCIBS_BRAKE_START:
			begin
				if (tmr_reg == 16'h0 || !run_cmd_in)
				begin
					st_next = run_cmd_in ? DCIBS_RUN : DCIBS_IDLE;
					rel_next = run_cmd_in; // [RULE19]
				end
			end
			DCIBS_STOPPED:
			begin
				if (!run_cmd_in && !decel_in)
					st_next = DCIBS_IDLE;
			end
			default: st_next = DCIBS_IDLE;
		endcase
		braking = (st_reg == DCIBS_BRAKE_STOP) || (st_reg == DCIBS_BRAKE_START);
		// start force when braking before acceleration [RULE4] [RULE6] [RULE11]
		force_sel = (st_reg == DCIBS_BRAKE_START || (xb_reg && !run_cmd_in && !decel_in)) ?
			tforce_reg : sforce_reg;
	end

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			st_reg <= DCIBS_IDLE;
			tmr_reg <= 16'h0;
			xb_reg <= 1'b0;
			rel_reg <= 1'b0;
			run_q_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			tmr_reg <= tmr_next;
			xb_reg <= xb_next;
			rel_reg <= rel_next;
			run_q_reg <= run_cmd_in;
		end
	end

	// ------------------------------------------------------------
	// braking carrier and outputs
	// ------------------------------------------------------------
	logic [15:0] force_eff;
	logic act_reg, off_reg;

	dcibs_carrier u_carrier (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.enable_in(braking), // [RULE17]
		.carrier_in(car_reg),
		.force_in(force_sel),
		.pwm_out(brake_pwm_out),
		.force_eff_out(force_eff)
	);

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			act_reg <= 1'b0;
			off_reg <= 1'b0;
		end
		else
		begin
			act_reg <= braking;
			off_reg <= (st_reg == DCIBS_WAIT) || (st_reg == DCIBS_STOPPED); // [RULE2]
		end
	end

	assign status = {9'h0, req_lvl, xb_reg, ext_mode, braking, 3'(st_reg)};
	assign reg_rdata_out = rdata_reg;
	assign brake_active_out = act_reg;
	assign output_off_out = off_reg;
	assign brake_force_out = force_eff;
	assign accel_release_out = rel_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence seq_wait_done;
		st_reg == DCIBS_WAIT && tmr_reg == 16'h0 && !xb_reg;
	endsequence

	AST_WAIT_TO_BRAKE: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE2]
		seq_wait_done |=> st_reg == DCIBS_BRAKE_STOP ##1 brake_active_out)
		else $error("wait end did not start braking");
	AST_OFF_IN_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE2]
		st_reg == DCIBS_WAIT |=> output_off_out)
		else $error("output not off while waiting");
	AST_FREQ_TRIG: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE1]
		st_reg == DCIBS_RUN && !ext_mode && freq_hit && stop_en |=> st_reg == DCIBS_WAIT)
		else $error("frequency threshold ignored");
	AST_EXT_IGNORES_EN: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE10]
		ext_mode && st_reg == DCIBS_IDLE && run_cmd_in && !ext_trig |=>
		st_reg != DCIBS_BRAKE_START)
		else $error("start brake in external mode");
	AST_LEVEL_RELEASE: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE13]
		st_reg == DCIBS_BRAKE_STOP && xb_reg && det_reg == DETECT_LEVEL && !req_lvl |=>
		!braking ##1 !brake_active_out)
		else $error("level release did not end braking");
	AST_EDGE_STOP_IGNORED: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE15]
		ext_mode && det_reg == DETECT_EDGE && st_reg == DCIBS_IDLE && !run_cmd_in |=>
		st_reg != DCIBS_WAIT)
		else $error("edge taken in stop state");
	AST_START_DUR_END: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE19]
		st_reg == DCIBS_BRAKE_START && tmr_reg == 16'h0 && run_cmd_in |=>
		accel_release_out && st_reg == DCIBS_RUN)
		else $error("start braking did not hand over");
	AST_DERATE: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE18]
		brake_force_out <= FORCE_MAX - 16'($past(car_reg) / 16'h0004))
		else $error("force above carrier limit");
endmodule : dcibs_top

// >>> verif/dcibs_motor_model.sv
// dcibs_motor_model: behavioural motor and output stage facing the sequencer
// assumes: frequency in 0.01 Hz units, sequencer outputs registered on mclk_in
`timescale 1ns/1ps
module dcibs_motor_model
#(
	parameter int unsigned STOP_CYC = 4
)
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// drive commands and sequencer outputs
	input wire logic run_in,
	input wire logic decel_in,
	input wire logic brake_in,
	input wire logic off_in,
	// motor state
	output logic [15:0] freq_out,
	output logic stopped_out
);
	int unsigned still_cnt;

	// ------
	// speed: ramp up on run, pulled down by decel, braking or coasting
	// ------
	always @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			freq_out <= 16'h0000;
			still_cnt <= 0;
		end
		else
		begin
			if ((decel_in || brake_in || off_in) && freq_out != 16'h0000)
				freq_out <= freq_out - 16'h000A;
			else if (run_in && !decel_in && !brake_in && !off_in && freq_out < 16'h03E8)
				freq_out <= freq_out + 16'h000A;
			// standstill only after a few cycles at zero speed
			if (freq_out == 16'h0000 && (brake_in || !run_in))
				still_cnt <= (still_cnt < STOP_CYC) ? still_cnt + 1 : STOP_CYC;
			else
				still_cnt <= 0;
		end
	end

	assign stopped_out = (still_cnt == STOP_CYC);
endmodule : dcibs_motor_model

// >>> verif/dcibs_top_tb.sv
// dcibs_top_tb: self-checking bench of the dc injection brake sequencer
// assumes: dcibs_pkg and design compiled first, motor model beside the sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module dcibs_top_tb;
	import dcibs_pkg::*;
	localparam int unsigned T = 10;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] reg_addr_in = 4'h0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic run_cmd_in = 1'b0;
	logic decel_in = 1'b0;
	logic motor_stopped_in;
	logic [15:0] out_freq_in;
	logic ext_brake_request_in = 1'b0;
	logic brake_active_out;
	logic output_off_out;
	logic brake_pwm_out;
	logic accel_release_out;
	logic [15:0] brake_force_out;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	dcibs_top #(.TICK_LEN(T)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .run_cmd_in(run_cmd_in),
		.decel_in(decel_in), .motor_stopped_in(motor_stopped_in), .out_freq_in(out_freq_in),
		.ext_brake_request_in(ext_brake_request_in), .brake_active_out(brake_active_out),
		.output_off_out(output_off_out), .brake_pwm_out(brake_pwm_out),
		.brake_force_out(brake_force_out), .accel_release_out(accel_release_out));
	dcibs_motor_model i_motor (.mclk_in(mclk_in), .rst_in(rst_in), .run_in(run_cmd_in),
		.decel_in(decel_in), .brake_in(brake_active_out), .off_in(output_off_out),
		.freq_out(out_freq_in), .stopped_out(motor_stopped_in));

	initial forever #2 mclk_in = ~mclk_in;

	// hang guard
	always @(posedge mclk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	// ------
	// bus and drive helpers
	// ------
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask : reg_rd

	task automatic setup(input logic [15:0] en, wt, sf, sd, ff, fd, det, car, cf);
		reg_wr(REG_ENABLE_OFS, en);
		reg_wr(REG_WAIT_OFS, wt);
		reg_wr(REG_STOP_FORCE_OFS, sf);
		reg_wr(REG_STOP_DUR_OFS, sd);
		reg_wr(REG_START_FORCE_OFS, ff);
		reg_wr(REG_START_DUR_OFS, fd);
		reg_wr(REG_DETECT_OFS, det);
		reg_wr(REG_CARRIER_OFS, car);
		reg_wr(REG_CONFIG_OFS, cf);
	endtask : setup

	task automatic drive(input logic r, input logic d, input logic q);
		@(posedge mclk_in);
		run_cmd_in <= r;
		decel_in <= d;
		ext_brake_request_in <= q;
	endtask : drive

	// sel 0 braking, 1 output off, 2 accel release
	task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
		logic s;
		cnt = 0;
		do
		begin
			@(posedge mclk_in);
			#1;
			s = (sel == 0) ? brake_active_out : (sel == 1) ? output_off_out : accel_release_out;
			cnt++;
		end
		while (s !== lvl && cnt < lim);
	endtask : wait_sig

	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// ------
	// scenarios
	// ------
	task automatic t_defaults();
		logic [15:0] d;
		logic [15:0] exp [11] = '{16'(RST_ENABLE), RST_START_FREQ, RST_WAIT, RST_FORCE, RST_DUR,
			16'(RST_DETECT), RST_FORCE, RST_DUR, RST_CARRIER, RST_CONFIG, 16'h0000};
		for (int i = 0; i < 11; i++)
		begin
			reg_rd(4'(i), d);
			`CHK(d, exp[i])
		end
		reg_rd(4'hB, d);
		`CHK(d, 16'h0000)
		`CHK({brake_active_out, brake_pwm_out}, 2'h0)
	endtask : t_defaults

	task automatic t_clamp();
		logic [15:0] d;
		logic [3:0] a [7] = '{4'h0, 4'h0, 4'h3, 4'h8, 4'h1, 4'h2, 4'h4};
		logic [15:0] w [7] = '{16'h0001, 16'h0003, 16'h00FF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
		logic [15:0] e [7] = '{16'h0001, 16'h0001, FORCE_MAX, CARRIER_MIN, START_FREQ_MAX,
			WAIT_MAX, DUR_MAX};
		for (int i = 0; i < 7; i++)
		begin
			reg_wr(a[i], w[i]);
			reg_rd(a[i], d);
			`CHK(d, e[i])
		end
		reg_wr(REG_START_FREQ_OFS, 16'h0064);
	endtask : t_clamp

	task automatic t_stop();
		setup(16'h1, 16'h2, 16'h28, 16'h3, 16'h0, 16'h0, 16'h1, 16'h1E, 16'h1);
		drive(1'b1, 1'b0, 1'b0);
		repeat (120) @(posedge mclk_in);
		drive(1'b1, 1'b1, 1'b0);
		wait_sig(1, 1'b1, 300, n);
		`CHK(out_freq_in < 16'h0064, 1'b1)
		`CHK(brake_active_out, 1'b0)
		wait_sig(0, 1'b1, 60, n);
		`CHK(n inside {[10:35]}, 1'b1)
		`CHK(brake_force_out, 16'h0028)
		wait_sig(0, 1'b0, 60, n);
		`CHK(n inside {[20:45]}, 1'b1)
		`CHK(output_off_out, 1'b1)
		drive(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk_in);
	endtask : t_stop

	task automatic t_start();
		setup(16'h1, 16'h0, 16'h0, 16'h0, 16'h14, 16'h2, 16'h1, 16'h1E, 16'h2);
		drive(1'b1, 1'b0, 1'b0);
		wait_sig(0, 1'b1, 10, n);
		`CHK(brake_active_out, 1'b1)
		`CHK(brake_force_out, 16'h0014)
		wait_sig(2, 1'b1, 40, n);
		`CHK(n inside {[10:30]}, 1'b1)
		wait_sig(0, 1'b0, 3, n);
		`CHK(brake_active_out, 1'b0)
		repeat (100) @(posedge mclk_in);
		drive(1'b1, 1'b1, 1'b0);
		wait_sig(0, 1'b1, 200, n);
		`CHK(brake_active_out, 1'b0)
		drive(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk_in);
	endtask : t_start

	task automatic t_freq_only();
		setup(16'h2, 16'h0, 16'h1E, 16'h2, 16'h14, 16'h2, 16'h1, 16'h1E, 16'h3);
		drive(1'b1, 1'b0, 1'b0);
		wait_sig(0, 1'b1, 40, n);
		`CHK(brake_active_out, 1'b0)
		repeat (100) @(posedge mclk_in);
		drive(1'b1, 1'b1, 1'b0);
		wait_sig(0, 1'b1, 200, n);
		`CHK(brake_active_out, 1'b1)
		`CHK(brake_force_out, 16'h001E)
		wait_sig(0, 1'b0, 60, n);
		drive(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk_in);
	endtask : t_freq_only

	task automatic t_ext_level();
		setup(16'h0, 16'h1, 16'h50, 16'h3, 16'h50, 16'h3, 16'h1, 16'h96, 16'h3C);
		drive(1'b0, 1'b0, 1'b1);
		wait_sig(1, 1'b1, 15, n);
		`CHK(output_off_out, 1'b1)
		wait_sig(0, 1'b1, 30, n);
		`CHK(n inside {[1:25]}, 1'b1)
		`CHK(brake_force_out, 16'h002B)
		repeat (80) @(posedge mclk_in);
		`CHK(brake_active_out, 1'b1)
		drive(1'b0, 1'b0, 1'b0);
		wait_sig(0, 1'b0, 12, n);
		`CHK(brake_active_out, 1'b0)
	endtask : t_ext_level

	task automatic t_ext_edge();
		// edge sensing only where no braking before acceleration is wanted
		setup(16'h0, 16'h0, 16'h28, 16'h3, 16'h14, 16'h3, 16'h0, 16'h1E, 16'h3C);
		drive(1'b0, 1'b0, 1'b1);
		wait_sig(0, 1'b1, 30, n);
		`CHK(brake_active_out, 1'b0)
		drive(1'b1, 1'b0, 1'b0);
		repeat (120) @(posedge mclk_in);
		drive(1'b1, 1'b0, 1'b1);
		wait_sig(0, 1'b1, 15, n);
		`CHK(brake_active_out, 1'b1)
		drive(1'b1, 1'b0, 1'b0);
		wait_sig(0, 1'b0, 300, n);
		`CHK(n inside {[60:200]}, 1'b1)
		`CHK(motor_stopped_in, 1'b1)
		drive(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk_in);
	endtask : t_ext_edge

	initial
	begin
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_defaults();
		t_clamp();
		t_stop();
		t_start();
		t_freq_only();
		t_ext_level();
		t_ext_edge();
		give_verdict();
	end
endmodule : dcibs_top_tb
